// ### logic/gpio_pkg.sv
// Package: register map, field positions and reset values of the parallel port block
package gpio_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] port_a_latch_off = 4'h0;
  localparam logic [3:0] port_b_latch_off = 4'h1;
  localparam logic [3:0] port_c_latch_off = 4'h2;
  localparam logic [3:0] port_d_latch_off = 4'h3;
  localparam logic [3:0] port_a_direction_off = 4'h4;
  localparam logic [3:0] port_b_direction_off = 4'h5;
  localparam logic [3:0] port_c_direction_clockout_off = 4'h6;
  localparam logic [3:0] port_d_direction_off = 4'h7;
  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int addr_w = 4;
  localparam int port_w = 8;
  localparam int port_c_w = 6;
  localparam int clock_out_enable_bit = 7;
  localparam int clock_out_pin = 2;
  localparam int chan_sel_w = 5;
  localparam int port_d_chan_base = 8;
  localparam int port_d_chan_pins = 7;
  localparam int timer_clock_pin = 6;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] direction_rst = 8'h00;
  localparam logic [7:0] latch_init = 8'h00;
  localparam logic [7:0] read_rst = 8'h00;
endpackage : gpio_pkg

// ### logic/pin_sync.sv
// Module: two-stage synchroniser for a bank of pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int width = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  typedef struct packed {
    logic [width-1:0] meta_r;
    logic [width-1:0] sync_r;
  } state_s;
  state_s st_r;
  state_s st_nxt;

  // Elaboration-time guard: a bank needs at least one pin
  if (width < 1)
  begin : g_width_check
    $error("pin_sync width must be positive");
  end

  always_comb
  begin
    st_nxt.meta_r = async_in;
    st_nxt.sync_r = st_r.meta_r;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.sync_r;
endmodule : pin_sync
`default_nettype wire

// ### logic/chan_decode.sv
// Module: decodes converter channel select into per-pin converter-use flags
`timescale 1ns/100ps
`default_nettype none
module chan_decode (
  input wire logic [4:0] converter_channel_select,
  output logic [7:0] port_b_analog,
  output logic [7:0] port_d_analog
);
  // Channels 0..7 sit on port B, 8..14 on port D pins 0..6
  always_comb
  begin
    port_b_analog = '0;
    port_d_analog = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (converter_channel_select == 5'(i))
      begin
        port_b_analog[i] = 1'b1;
      end
    end
    for (int j = 0; j < gpio_pkg::port_d_chan_pins; j++)
    begin
      if (converter_channel_select == 5'(j + gpio_pkg::port_d_chan_base))
      begin
        port_d_analog[j] = 1'b1;
      end
    end
  end
endmodule : chan_decode
`default_nettype wire

// ### logic/four_port_parallel_io.sv
// Module: four-port parallel I/O with data latches, direction control and clock output
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module four_port_parallel_io (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [4:0] converter_channel_select,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n,
  input wire logic [5:0] port_c_in,
  output logic [5:0] port_c_out,
  output logic [5:0] port_c_oe_n,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe_n,
  output logic clock_out_enable,
  output logic timer_a_external_clock
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] port_a_latch_r;
    logic [7:0] port_b_latch_r;
    logic [5:0] port_c_latch_r;
    logic [7:0] port_d_latch_r;
    logic [7:0] port_a_direction_r;
    logic [7:0] port_b_direction_r;
    logic [5:0] port_c_direction_r;
    logic clock_out_enable_r;
    logic [7:0] port_d_direction_r;
    logic [7:0] rdata_r;
    logic [7:0] a_out_r;
    logic [7:0] a_oe_n_r;
    logic [7:0] b_out_r;
    logic [7:0] b_oe_n_r;
    logic [5:0] c_out_r;
    logic [5:0] c_oe_n_r;
    logic [7:0] d_out_r;
    logic [7:0] d_oe_n_r;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [7:0] a_sync;
  logic [7:0] b_sync;
  logic [5:0] c_sync;
  logic [7:0] d_sync;
  logic [7:0] b_analog;
  logic [7:0] d_analog;
  logic [7:0] timer_sync;

  // ****************************************
  // Pin synchronisers and channel decode
  // ****************************************
  pin_sync #(.width(8)) sync_a (.core_clk(core_clk), .rst_n(rst_n), .async_in(port_a_in), .sync_out(a_sync));
  pin_sync #(.width(8)) sync_b (.core_clk(core_clk), .rst_n(rst_n), .async_in(port_b_in), .sync_out(b_sync));
  pin_sync #(.width(6)) sync_c (.core_clk(core_clk), .rst_n(rst_n), .async_in(port_c_in), .sync_out(c_sync));
  pin_sync #(.width(8)) sync_d (.core_clk(core_clk), .rst_n(rst_n), .async_in(port_d_in), .sync_out(d_sync));
  assign timer_sync = d_sync;

  chan_decode decode (
    .converter_channel_select(converter_channel_select),
    .port_b_analog(b_analog),
    .port_d_analog(d_analog)
  );

  // Per-bit read value: latch when output, zero for analog input, else pin level
  function automatic logic [7:0] read_mux(input logic [7:0] latch, input logic [7:0] dir,
                                          input logic [7:0] pins, input logic [7:0] analog);
    logic [7:0] res;
    res = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (dir[i])
      begin
        res[i] = latch[i];
      end
      else if (analog[i])
      begin
        res[i] = 1'b0;
      end
      else
      begin
        res[i] = pins[i];
      end
    end
    return res;
  endfunction : read_mux

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    if (reg_wr)
    begin
      unique case (reg_addr)
        gpio_pkg::port_a_latch_off: st_nxt.port_a_latch_r = reg_wdata;
        gpio_pkg::port_b_latch_off: st_nxt.port_b_latch_r = reg_wdata;
        gpio_pkg::port_c_latch_off: st_nxt.port_c_latch_r = reg_wdata[5:0];
        gpio_pkg::port_d_latch_off: st_nxt.port_d_latch_r = reg_wdata;
        gpio_pkg::port_a_direction_off: st_nxt.port_a_direction_r = reg_wdata;
        gpio_pkg::port_b_direction_off: st_nxt.port_b_direction_r = reg_wdata;
        gpio_pkg::port_c_direction_clockout_off:
        begin
          st_nxt.port_c_direction_r = reg_wdata[5:0];
          st_nxt.clock_out_enable_r = reg_wdata[gpio_pkg::clock_out_enable_bit];
        end
        gpio_pkg::port_d_direction_off: st_nxt.port_d_direction_r = reg_wdata;
        default: st_nxt.port_a_latch_r = st_r.port_a_latch_r;
      endcase
    end
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata_r = gpio_pkg::read_rst;
    if (reg_rd)
    begin
      unique case (reg_addr)
        gpio_pkg::port_a_latch_off:
          st_nxt.rdata_r = read_mux(st_r.port_a_latch_r, st_r.port_a_direction_r, a_sync, 8'h00);
        gpio_pkg::port_b_latch_off:
          st_nxt.rdata_r = read_mux(st_r.port_b_latch_r, st_r.port_b_direction_r, b_sync, b_analog);
        gpio_pkg::port_c_latch_off:
          st_nxt.rdata_r = read_mux({2'h0, st_r.port_c_latch_r}, {2'h0, st_r.port_c_direction_r},
                                    {2'h0, c_sync}, 8'h00);
        gpio_pkg::port_d_latch_off:
          st_nxt.rdata_r = read_mux(st_r.port_d_latch_r, st_r.port_d_direction_r, d_sync, d_analog);
        gpio_pkg::port_a_direction_off: st_nxt.rdata_r = st_r.port_a_direction_r;
        gpio_pkg::port_b_direction_off: st_nxt.rdata_r = st_r.port_b_direction_r;
        gpio_pkg::port_c_direction_clockout_off:
          st_nxt.rdata_r = {st_r.clock_out_enable_r, 1'b0, st_r.port_c_direction_r};
        gpio_pkg::port_d_direction_off: st_nxt.rdata_r = st_r.port_d_direction_r;
        default: st_nxt.rdata_r = gpio_pkg::read_rst;
      endcase
    end
    // Pin drive follows the registered latch and direction; one cycle of lag keeps outputs glitch-free
    st_nxt.a_out_r = st_r.port_a_latch_r;
    st_nxt.a_oe_n_r = ~st_r.port_a_direction_r;
    st_nxt.b_out_r = st_r.port_b_latch_r;
    st_nxt.b_oe_n_r = ~st_r.port_b_direction_r | b_analog;
    st_nxt.c_out_r = st_r.port_c_latch_r;
    st_nxt.c_oe_n_r = ~st_r.port_c_direction_r;
    if (st_r.clock_out_enable_r)
    begin
      // Clock itself is muxed onto the pin outside, flops cannot carry core_clk
      st_nxt.c_oe_n_r[gpio_pkg::clock_out_pin] = 1'b0;
      st_nxt.c_out_r[gpio_pkg::clock_out_pin] = 1'b0;
    end
    st_nxt.d_out_r = st_r.port_d_latch_r;
    st_nxt.d_oe_n_r = ~st_r.port_d_direction_r | d_analog;
  end

  // ****************************************
  // Registers
  // ****************************************
  // Latches and drive values are left out of the reset branch: reset must not touch them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.port_a_direction_r <= gpio_pkg::direction_rst;
      st_r.port_b_direction_r <= gpio_pkg::direction_rst;
      st_r.port_c_direction_r <= gpio_pkg::direction_rst[5:0];
      st_r.clock_out_enable_r <= 1'b0;
      st_r.port_d_direction_r <= gpio_pkg::direction_rst;
      st_r.rdata_r <= gpio_pkg::read_rst;
      st_r.a_oe_n_r <= 8'hFF;
      st_r.b_oe_n_r <= 8'hFF;
      st_r.c_oe_n_r <= 6'h3F;
      st_r.d_oe_n_r <= 8'hFF;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = st_r.rdata_r;
  assign port_a_out = st_r.a_out_r;
  assign port_a_oe_n = st_r.a_oe_n_r;
  assign port_b_out = st_r.b_out_r;
  assign port_b_oe_n = st_r.b_oe_n_r;
  assign port_c_out = st_r.c_out_r;
  assign port_c_oe_n = st_r.c_oe_n_r;
  assign port_d_out = st_r.d_out_r;
  assign port_d_oe_n = st_r.d_oe_n_r;
  assign clock_out_enable = st_r.clock_out_enable_r;
  assign timer_a_external_clock = timer_sync[gpio_pkg::timer_clock_pin];
endmodule : four_port_parallel_io
`default_nettype wire

// ### test/pin_bank_model.sv
// Partner model: outside pins that resolve block drive against the outside level
`timescale 1ns/100ps
`default_nettype none
module pin_bank_model #(
  parameter int width = 8
) (
  input wire logic [width-1:0] drv,
  input wire logic [width-1:0] oe_n,
  input wire logic [width-1:0] ext,
  output logic [width-1:0] pin
);
  // Outside source wins only where the block has let go of the pin
  assign pin = (drv & ~oe_n) | (ext & oe_n);
endmodule : pin_bank_model
`default_nettype wire

// ### test/four_port_parallel_io_checker.sv
// Checker: port-level timing properties of the parallel port block
`timescale 1ns/100ps
`default_nettype none
module four_port_parallel_io_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [4:0] converter_channel_select,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_oe_n,
  input wire logic [5:0] port_c_oe_n,
  input wire logic [7:0] port_d_in,
  input wire logic [7:0] port_d_oe_n,
  input wire logic clock_out_enable,
  input wire logic timer_a_external_clock
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  AST_RST_DIR: assert property ($rose(rst_n) |-> &port_a_oe_n && &port_d_oe_n)
    else $error("pins not inputs after reset");
  AST_RST_CLK: assert property ($rose(rst_n) |-> !clock_out_enable)
    else $error("clock output on after reset");
  AST_DIR_A: assert property (reg_wr && reg_addr == gpio_pkg::port_a_direction_off
    |-> ##2 port_a_oe_n == ~$past(reg_wdata, 2))
    else $error("port A enables differ from direction");
  AST_OUT_A: assert property (reg_wr && reg_addr == gpio_pkg::port_a_latch_off
    |-> ##2 port_a_out == $past(reg_wdata, 2))
    else $error("port A drive differs from latch");
  AST_CLK_EN: assert property (reg_wr && reg_addr == gpio_pkg::port_c_direction_clockout_off
    |-> ##2 clock_out_enable == $past(reg_wdata[gpio_pkg::clock_out_enable_bit], 2))
    else $error("clock enable differs from bit 7");
  // Pin enables are registered one cycle behind the enable bit
  AST_CLK_PIN: assert property (clock_out_enable |=> !port_c_oe_n[gpio_pkg::clock_out_pin])
    else $error("clock pin not driven");
  AST_ANA_B: assert property ($stable(converter_channel_select) && converter_channel_select < 5'h08
    |-> port_b_oe_n[converter_channel_select[2:0]])
    else $error("converter pin on port B driven");
  AST_ANA_D: assert property ($stable(converter_channel_select) && converter_channel_select inside {[5'h08:5'h0E]}
    |-> port_d_oe_n[converter_channel_select[2:0]])
    else $error("converter pin on port D driven");
  // Synchroniser must have run out of reset for two edges before the comparison holds
  AST_TMR: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> timer_a_external_clock == $past(port_d_in[gpio_pkg::timer_clock_pin], 2))
    else $error("timer clock not two stages after pin");
  cover property (reg_rd ##1 reg_rdata != 8'h00);
  cover property (clock_out_enable);
  cover property (converter_channel_select < 5'h08 && reg_rd && reg_addr == 4'h1);
endmodule : four_port_parallel_io_checker
bind four_port_parallel_io four_port_parallel_io_checker i_chk (.core_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .converter_channel_select, .port_a_out, .port_a_oe_n, .port_b_oe_n,
  .port_c_oe_n, .port_d_in, .port_d_oe_n, .clock_out_enable, .timer_a_external_clock);
`default_nettype wire

// ### test/test_four_port_parallel_io.sv
// Testbench: register walk, converter sharing, clock output and reset
`timescale 1ns/100ps
`default_nettype none
module test_four_port_parallel_io;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic core_clk, rst_n, reg_wr, reg_rd, clock_out_enable, timer_a_external_clock;
  logic [3:0] reg_addr;
  logic [4:0] converter_channel_select;
  logic [7:0] reg_wdata, reg_rdata, rd, a_in, a_out, a_oe, b_in, b_out, b_oe, d_in, d_out, d_oe, a_x, b_x, d_x;
  logic [5:0] c_in, c_out, c_oe, c_x, c_drv;
  int miscompares = 0;
  int checked = 0;
  // Outside levels 5A C3 2D 96; expected reads mix latch and pin per direction bit
  row_s rows [13] = '{'{4'h0, 8'h3C, 8'h5A}, '{4'h4, 8'hF0, 8'hF0}, '{4'h0, 8'h3C, 8'h3A},
    '{4'h6, 8'hFF, 8'hBF}, '{4'h2, 8'hFF, 8'h3F}, '{4'h6, 8'h00, 8'h00}, '{4'h2, 8'h00, 8'h2D},
    '{4'h8, 8'hFF, 8'h00}, '{4'hF, 8'h55, 8'h00}, '{4'h5, 8'h0F, 8'h0F}, '{4'h1, 8'hAA, 8'hCA},
    '{4'h7, 8'h00, 8'h00}, '{4'h3, 8'h11, 8'h96}};
  // Clock out replaces the latch on C2 outside the block
  assign c_drv = {c_out[5:3], clock_out_enable ? core_clk : c_out[2], c_out[1:0]};
  four_port_parallel_io i_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .converter_channel_select, .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe),
    .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe), .port_c_in(c_in), .port_c_out(c_out),
    .port_c_oe_n(c_oe), .port_d_in(d_in), .port_d_out(d_out), .port_d_oe_n(d_oe), .clock_out_enable,
    .timer_a_external_clock);
  pin_bank_model i_pa (.drv(a_out), .oe_n(a_oe), .ext(a_x), .pin(a_in));
  pin_bank_model i_pb (.drv(b_out), .oe_n(b_oe), .ext(b_x), .pin(b_in));
  pin_bank_model #(.width(6)) i_pc (.drv(c_drv), .oe_n(c_oe), .ext(c_x), .pin(c_in));
  pin_bank_model i_pd (.drv(d_out), .oe_n(d_oe), .ext(d_x), .pin(d_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : rdr
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Hang guard: the whole run is far shorter than this
  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    converter_channel_select = 5'h1F;
    a_x = 8'h5A;
    b_x = 8'hC3;
    c_x = 6'h2D;
    d_x = 8'h96;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // Port A latch is loaded before its direction turns on; ports B and C get their direction first
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rdr(rows[i].a);
      chk(rd, rows[i].e);
    end
    chk(a_oe, 8'h0F);
    chk(a_in, 8'h3A);
    chk(b_out, 8'hAA);
    chk({2'h0, c_out}, 8'h00);
    chk(d_out, 8'h11);
    chk(d_oe, 8'hFF);
    @(posedge core_clk) converter_channel_select <= 5'h06;
    rdr(4'h1);
    chk(rd, 8'h8A);
    @(posedge core_clk) converter_channel_select <= 5'h01;
    rdr(4'h1);
    chk(rd, 8'hCA);
    chk(b_oe, 8'hF2);
    @(posedge core_clk) converter_channel_select <= 5'h09;
    rdr(4'h3);
    chk(rd, 8'h94);
    wr(4'h7, 8'hFF);
    rdr(4'h3);
    chk(rd, 8'h11);
    chk(d_oe, 8'h02);
    wr(4'h7, 8'h00);
    @(posedge core_clk) converter_channel_select <= 5'h1F;
    d_x <= 8'hD6;
    wr(4'h6, 8'h80);
    repeat (2) @(posedge core_clk);
    #1;
    chk({7'h00, clock_out_enable}, 8'h01);
    chk({2'h0, c_oe}, 8'h3B);
    chk({7'h00, timer_a_external_clock}, 8'h01);
    wr(4'h4, 8'hFF);
    @(posedge core_clk) rst_n <= 1'b0;
    #1;
    chk(a_oe, 8'hFF);
    chk({7'h00, clock_out_enable}, 8'h00);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(4'h4, 8'hFF);
    rdr(4'h0);
    chk(rd, 8'h3C);
    rdr(4'h6);
    chk(rd, 8'h00);
    stop_test();
  end
endmodule : test_four_port_parallel_io
`default_nettype wire
